/* File: crpa_params.svh */
// Purpose: constants for the calculation RAM pointer arbiter
// Assumes: included by the package and the design modules
// Notes: register word offsets are byte addresses on the AHB-Lite bus
`ifndef CRPA_PARAMS_SVH
`define CRPA_PARAMS_SVH
`define CRPA_OFF_A_PTR 8'h00
`define CRPA_OFF_X_PTR 8'h04
`define CRPA_OFF_R_PTR 8'h08
`define CRPA_OFF_H_PTR 8'h0c
`define CRPA_OFF_STATUS 8'h10
`define CRPA_PTR_RESET 8'h00
`define CRPA_RAM_DEPTH 256
`define CRPA_SFR_BASE 8'h80
`define CRPA_HTRANS_NONSEQ 2'h2
`define CRPA_HRESP_OKAY 1'h0
`endif

/* File: crpa_pkg.sv */
// Purpose: shared types for the calculation RAM pointer arbiter
// Assumes: crpa_params.svh defines the constants
// Notes: none
`include "crpa_params.svh"
package crpa_pkg;
   // Calculation unit pointer controls, one cycle each except the active level
   typedef struct packed {
      logic active;
      logic cycleStart;
      logic decA;
      logic decX;
      logic decR;
      logic incH;
   } crpa_calc_ctl_t;
   // Selector for the RAM address source
   typedef enum logic [3:0] {
      SRC_CPU = 4'h1,
      SRC_A = 4'h2,
      SRC_X = 4'h4,
      SRC_R = 4'h8
   } crpa_src_t;
   // Arbiter states
   typedef enum logic [1:0] {
      ST_STANDBY = 2'h1,
      ST_ACTIVE = 2'h2
   } crpa_state_t;
endpackage : crpa_pkg

/* File: crpa_down_ptr.sv */
// Purpose: one 8-bit holding register with its 8-bit down counter
// Assumes: rstN is the synchronised reset
// Notes: holding register write has priority over nothing else
`timescale 1ns/10ps
`default_nettype none
`include "crpa_params.svh"
module crpa_down_ptr #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstN,
   // Controls
   input wire logic wrEn,
   input wire logic [W-1:0] wrData,
   input wire logic load,
   input wire logic dec,
   // State
   output logic [W-1:0] holdVal,
   output logic [W-1:0] countVal
);
   logic [W-1:0] hold_reg;
   logic [W-1:0] count_reg;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         hold_reg <= W'(`CRPA_PTR_RESET);
      end else if (wrEn) begin
         hold_reg <= wrData;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count_reg <= W'(`CRPA_PTR_RESET);
      end else if (load) begin
         count_reg <= hold_reg;
      end else if (dec) begin
         count_reg <= count_reg - W'(1);
      end
   end

   assign holdVal = hold_reg;
   assign countVal = count_reg;
endmodule : crpa_down_ptr
`default_nettype wire

/* File: crpa_ram.sv */
// Purpose: 256-byte flip-flop RAM with one port
// Assumes: caller arbitrates between CPU and calculation unit
// Notes: read data is registered
`timescale 1ns/10ps
`default_nettype none
`include "crpa_params.svh"
module crpa_ram #(
   parameter int DEPTH = `CRPA_RAM_DEPTH,
   parameter int AW = 8
) (
   // Clock
   input wire logic clk,
   // Port
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : crpa_ram
`default_nettype wire

/* File: crpa_calc_ram_arbiter.sv */
// Purpose: RAM pointers and CPU/calculation unit RAM arbitration
// Assumes: calculation unit and CPU RAM ports are on core_clk
// Notes: pointer registers are reached over AHB-Lite, zero wait
// Function
// - The 256-byte RAM serves either the CPU or the unit, never both.
// - The CPU has full RAM access only while the unit is idle.
// - While the unit is active, it uses its own channel; CPU RAM access is blocked.
// - Interrupt grants to the CPU are withheld while the unit is active.
// - While active, only the special function registers stay CPU accessible.
// - Three pointers each have an 8-bit holding register and down counter.
// - CPU writes the holding register and reads the down counter.
// - All holding registers and down counters reset to 00H.
// - The high-operand pointer is a CPU read/write up counter, reset 00H.
// - In standby, the unit makes no RAM accesses.
// - In standby, down counters reload from holding registers every cycle.
// - When active, reloading stops and the unit controls counting.
// - When active, pointers address operand and result fields.
// - Holding registers may be rewritten while active; loaded at next cycle start.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "crpa_params.svh"
module crpa_calc_ram_arbiter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Calculation unit
   input wire crpa_pkg::crpa_calc_ctl_t calcCtl,
   input wire crpa_pkg::crpa_src_t calcSrc,
   input wire logic calcWe,
   input wire logic [7:0] calcWdata,
   output logic [7:0] calcRdata,
   // CPU RAM port
   input wire logic cpuReq,
   input wire logic cpuWe,
   input wire logic [7:0] cpuAddr,
   input wire logic [7:0] cpuWdata,
   output logic [7:0] cpuRdata,
   output logic cpuBlocked,
   // Interrupt grant
   input wire logic irqReq,
   output logic irqGrant
);
   logic rstSync1_reg;
   logic rstN;
   crpa_pkg::crpa_state_t state_reg;
   logic active;
   logic [7:0] highPtr_reg;
   logic [7:0] aHold, aCnt, xHold, xCnt, rHold, rCnt;
   logic dpWr_reg;
   logic [7:0] dpAddr_reg;
   logic wrA, wrX, wrR, wrH;
   logic loadCnt;
   logic [7:0] ramAddr;
   logic ramWe;
   logic [7:0] ramWdata;
   logic [7:0] ramRdata;
   logic isSfr;
   logic cpuOk;
   logic [31:0] rdMux;
   logic [7:0] cpuRdata_next;
   logic cpuSel_reg;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync1_reg <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstSync1_reg <= 1'b1;
         rstN <= rstSync1_reg;
      end
   end

   function automatic logic isOff(input logic [7:0] a, input logic [7:0] o);
      isOff = (a == o);
   endfunction : isOff

   // Unit activity state
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= crpa_pkg::ST_STANDBY;
      end else begin
         state_reg <= calcCtl.active ? crpa_pkg::ST_ACTIVE
                                     : crpa_pkg::ST_STANDBY;
      end
   end

   // Mux follows the live activity input so the switch is immediate
   assign active = calcCtl.active;

   // Bus address phase capture
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         dpWr_reg <= 1'b0;
         dpAddr_reg <= 8'h00;
      end else if (hready) begin
         dpWr_reg <= hsel && hwrite && (htrans == `CRPA_HTRANS_NONSEQ);
         dpAddr_reg <= haddr[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         hreadyout <= 1'b1;
         hresp <= `CRPA_HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= `CRPA_HRESP_OKAY;
      end
   end

   assign wrA = dpWr_reg && isOff(dpAddr_reg, `CRPA_OFF_A_PTR);
   assign wrX = dpWr_reg && isOff(dpAddr_reg, `CRPA_OFF_X_PTR);
   assign wrR = dpWr_reg && isOff(dpAddr_reg, `CRPA_OFF_R_PTR);
   assign wrH = dpWr_reg && isOff(dpAddr_reg, `CRPA_OFF_H_PTR);

   // Continuous reload in standby, else only at a new calculation cycle
   assign loadCnt = !calcCtl.active || calcCtl.cycleStart;

   crpa_down_ptr #(.W(8)) uPtrA (
      .clk(core_clk), .rstN(rstN), .wrEn(wrA), .wrData(hwdata[7:0]),
      .load(loadCnt), .dec(calcCtl.active && calcCtl.decA),
      .holdVal(aHold), .countVal(aCnt)
   );
   crpa_down_ptr #(.W(8)) uPtrX (
      .clk(core_clk), .rstN(rstN), .wrEn(wrX), .wrData(hwdata[7:0]),
      .load(loadCnt), .dec(calcCtl.active && calcCtl.decX),
      .holdVal(xHold), .countVal(xCnt)
   );
   crpa_down_ptr #(.W(8)) uPtrR (
      .clk(core_clk), .rstN(rstN), .wrEn(wrR), .wrData(hwdata[7:0]),
      .load(loadCnt), .dec(calcCtl.active && calcCtl.decR),
      .holdVal(rHold), .countVal(rCnt)
   );

   // Up counter; a CPU write wins over an increment in the same cycle
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         highPtr_reg <= `CRPA_PTR_RESET;
      end else if (wrH) begin
         highPtr_reg <= hwdata[7:0];
      end else if (calcCtl.active && calcCtl.incH) begin
         highPtr_reg <= highPtr_reg + 8'h01;
      end
   end

   // Register reads: counters, not holding registers
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (dpAddr_reg)
         `CRPA_OFF_A_PTR: rdMux[7:0] = aCnt;
         `CRPA_OFF_X_PTR: rdMux[7:0] = xCnt;
         `CRPA_OFF_R_PTR: rdMux[7:0] = rCnt;
         `CRPA_OFF_H_PTR: rdMux[7:0] = highPtr_reg;
         `CRPA_OFF_STATUS: rdMux[0] = (state_reg == crpa_pkg::ST_ACTIVE);
         default: rdMux = 32'h0000_0000;
      endcase
   end
   assign hrdata = rdMux;

   // SFR window stays open to the CPU during activity
   assign isSfr = (cpuAddr >= `CRPA_SFR_BASE);
   assign cpuOk = !active;

   // RAM address and write mux
   always_comb begin
      ramAddr = cpuAddr;
      ramWe = 1'b0;
      ramWdata = cpuWdata;
      if (active) begin
         ramWdata = calcWdata;
         ramWe = calcWe;
         unique case (calcSrc)
            crpa_pkg::SRC_A: ramAddr = aCnt;
            crpa_pkg::SRC_X: ramAddr = xCnt;
            crpa_pkg::SRC_R: ramAddr = rCnt;
            default: ramAddr = highPtr_reg;
         endcase
      end else begin
         ramWe = cpuReq && cpuWe && !isSfr;
      end
   end

   crpa_ram #(.DEPTH(`CRPA_RAM_DEPTH), .AW(8)) uRam (
      .clk(core_clk), .we(ramWe), .addr(ramAddr),
      .wdata(ramWdata), .rdata(ramRdata)
   );

   assign calcRdata = ramRdata;
   // Remember who addressed the RAM, so unit data never reaches the CPU
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         cpuSel_reg <= 1'b0;
      end else begin
         cpuSel_reg <= cpuOk;
      end
   end

   assign cpuRdata_next = cpuSel_reg ? ramRdata : 8'h00;

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         cpuRdata <= 8'h00;
      end else begin
         cpuRdata <= cpuRdata_next;
      end
   end

   // Blocked flags RAM only; SFR accesses go elsewhere and stay allowed
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         cpuBlocked <= 1'b0;
      end else begin
         cpuBlocked <= calcCtl.active && cpuReq && !isSfr;
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         irqGrant <= 1'b0;
      end else begin
         irqGrant <= irqReq && !calcCtl.active;
      end
   end

   // Checks
   standby_reload_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      !calcCtl.active && !wrA |=> aCnt == $past(aHold))
      else $error("down counter not reloaded in standby");
   hold_active_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active && !calcCtl.cycleStart && !calcCtl.decA
      |=> aCnt == $past(aCnt))
      else $error("counter moved without unit command");
   dec_step_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active && !calcCtl.cycleStart && calcCtl.decX
      |=> xCnt == $past(xCnt) - 8'h01)
      else $error("counter did not decrement");
   irq_block_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active |=> !irqGrant)
      else $error("interrupt granted while active");
   irq_pass_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      !calcCtl.active && irqReq |=> irqGrant)
      else $error("interrupt not granted in standby");
   mux_switch_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active && calcSrc == crpa_pkg::SRC_R |-> ramAddr == rCnt)
      else $error("address mux not on result pointer");
   mux_cpu_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      !calcCtl.active |-> ramAddr == cpuAddr)
      else $error("address mux not on CPU address");
   cpu_nowrite_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active && !calcWe |-> !ramWe)
      else $error("CPU write reached RAM while active");
   idle_nowrite_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      !calcCtl.active && !cpuReq |-> !ramWe)
      else $error("RAM written in standby without CPU request");
   cpu_rd_block_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active |-> ##2 cpuRdata == 8'h00)
      else $error("RAM data reached the CPU while active");
   up_count_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active && calcCtl.incH && !wrH
      |=> highPtr_reg == $past(highPtr_reg) + 8'h01)
      else $error("high pointer did not increment");
   high_write_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      wrH |=> highPtr_reg == $past(hwdata[7:0]))
      else $error("high pointer write lost");
   hold_write_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active && wrR |=> rHold == $past(hwdata[7:0]))
      else $error("holding register write lost while active");
   hold_keep_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      !wrA |=> aHold == $past(aHold))
      else $error("holding register changed without write");
   load_start_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active && calcCtl.cycleStart |=> aCnt == $past(aHold)
      && xCnt == $past(xHold) && rCnt == $past(rHold))
      else $error("counters not loaded at cycle start");
   cpu_block_a: assert property (
      @(posedge core_clk) disable iff (!rstN)
      calcCtl.active && cpuReq && !isSfr |=> cpuBlocked)
      else $error("CPU RAM access not flagged");
   cov_active_c: cover property (@(posedge core_clk) disable iff (!rstN)
      !calcCtl.active ##1 calcCtl.active);
   cov_cycle_c: cover property (@(posedge core_clk) disable iff (!rstN)
      calcCtl.active && calcCtl.cycleStart);
   cov_wr_c: cover property (@(posedge core_clk) disable iff (!rstN)
      calcCtl.active && wrA);
   cov_dec_c: cover property (@(posedge core_clk) disable iff (!rstN)
      calcCtl.active && calcCtl.decA);
   cov_block_c: cover property (@(posedge core_clk) disable iff (!rstN)
      cpuBlocked);
endmodule : crpa_calc_ram_arbiter
`default_nettype wire

/* File: crpa_calc_model.sv */
// Purpose: calculation unit model driving the pointer controls
// Assumes: the bench calls step once per unit operation
// Notes: gap stretches the idle time between operations
`timescale 1ns/10ps
`default_nettype none
module crpa_calc_model (
   // Clock
   input wire logic clk,
   // Unit side
   output var crpa_pkg::crpa_calc_ctl_t ctl,
   output var crpa_pkg::crpa_src_t src,
   output var logic we,
   output var logic [7:0] wd
);
   initial begin
      ctl = '0;
      src = crpa_pkg::SRC_CPU;
      we = 1'b0;
      wd = 8'h00;
   end
   // Pulses last one cycle; the level of act is held afterwards
   task automatic step(input logic act, input logic cs,
      input logic [3:0] cnt, input crpa_pkg::crpa_src_t s,
      input logic w, input logic [7:0] d, input int gap);
      @(posedge clk);
      ctl <= {act, cs, cnt};
      src <= s;
      we <= w;
      wd <= d;
      @(posedge clk);
      ctl <= {act, 5'h00};
      we <= 1'b0;
      repeat (gap) @(posedge clk);
   endtask : step
endmodule : crpa_calc_model
`default_nettype wire

/* File: crpa_testbench.sv */
// Purpose: self-checking bench for the RAM pointer arbiter
// Assumes: zero-wait bus slave, unit model in crpa_calc_model
// Notes: expected values follow from the pointer and arbitration rules
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin fails++; \
$display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module testbench;
   typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [31:0] e;}
      crpa_row_t;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hready, hreadyout, hresp;
   crpa_pkg::crpa_calc_ctl_t calcCtl;
   crpa_pkg::crpa_src_t calcSrc;
   logic calcWe;
   logic [7:0] calcWdata, calcRdata, cpuRdata, cr;
   logic [7:0] cpuAddr = 8'h00;
   logic [7:0] cpuWdata = 8'h00;
   logic cpuReq = 1'b0;
   logic cpuWe = 1'b0;
   logic irqReq = 1'b1;
   logic cpuBlocked, irqGrant, cb;
   int fails = 0;
   int nCompared = 0;
   // Reset values, writes, then readback of counters and a hole
   crpa_row_t rows[15] = '{
      '{0, 8'h00, 8'h00, 32'h0}, '{0, 8'h04, 8'h00, 32'h0},
      '{0, 8'h08, 8'h00, 32'h0}, '{0, 8'h0c, 8'h00, 32'h0},
      '{0, 8'h10, 8'h00, 32'h0}, '{1, 8'h00, 8'h20, 32'h0},
      '{1, 8'h04, 8'h40, 32'h0}, '{1, 8'h08, 8'h60, 32'h0},
      '{1, 8'h0c, 8'h10, 32'h0}, '{1, 8'h14, 8'hff, 32'h0},
      '{0, 8'h00, 8'h00, 32'h20}, '{0, 8'h04, 8'h00, 32'h40},
      '{0, 8'h08, 8'h00, 32'h60}, '{0, 8'h0c, 8'h00, 32'h10},
      '{0, 8'h14, 8'h00, 32'h0}};
   assign hready = hreadyout;
   always #50 core_clk = ~core_clk;
   crpa_calc_ram_arbiter uut (.core_clk(core_clk), .nrst(nrst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .calcCtl(calcCtl), .calcSrc(calcSrc), .calcWe(calcWe),
      .calcWdata(calcWdata), .calcRdata(calcRdata), .cpuReq(cpuReq),
      .cpuWe(cpuWe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
      .cpuRdata(cpuRdata), .cpuBlocked(cpuBlocked), .irqReq(irqReq),
      .irqGrant(irqGrant));
   crpa_calc_model unit (.clk(core_clk), .ctl(calcCtl), .src(calcSrc),
      .we(calcWe), .wd(calcWdata));
   task automatic report_and_stop;
      $display("compared %0d, wrong %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // A slave that never answers must not hang the run
   task automatic rdy;
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin
         fails++;
         report_and_stop();
      end
   endtask : rdy
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      rdy();
      rd = hrdata;
   endtask : bus
   // Read data lands two cycles after the address, the block flag after one
   task automatic cpu(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge core_clk);
      cpuReq <= 1'b1;
      cpuWe <= w;
      cpuAddr <= a;
      cpuWdata <= d;
      @(posedge core_clk);
      cpuReq <= 1'b0;
      cpuWe <= 1'b0;
      @(posedge core_clk);
      cb = cpuBlocked;
      @(posedge core_clk);
      cr = cpuRdata;
   endtask : cpu
   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) begin
            `CHK(rd, rows[i].e)
         end
      end
      cpu(1'b1, 8'h21, 8'ha5);
      cpu(1'b1, 8'h40, 8'h77);
      cpu(1'b0, 8'h21, 8'h00);
      `CHK(cr, 8'ha5)
      `CHK(irqGrant, 1'b1)
      unit.step(1'b1, 1'b1, 4'h0, crpa_pkg::SRC_A, 1'b0, 8'h00, 0);
      // New start address while the unit runs
      bus(1'b1, 8'h00, 8'h30);
      bus(1'b0, 8'h00, 8'h00);
      `CHK(rd, 32'h20)
      `CHK(irqGrant, 1'b0)
      unit.step(1'b1, 1'b0, 4'h3, crpa_pkg::SRC_R, 1'b1, 8'h3c, 2);
      unit.step(1'b1, 1'b0, 4'h0, crpa_pkg::SRC_X, 1'b0, 8'h00, 0);
      @(posedge core_clk);
      `CHK(calcRdata, 8'h77)
      bus(1'b0, 8'h08, 8'h00);
      `CHK(rd, 32'h5f)
      bus(1'b0, 8'h0c, 8'h00);
      `CHK(rd, 32'h11)
      bus(1'b0, 8'h10, 8'h00);
      `CHK(rd, 32'h1)
      cpu(1'b1, 8'h21, 8'h5a);
      `CHK(cb, 1'b1)
      `CHK(cr, 8'h00)
      cpu(1'b1, 8'h90, 8'h00);
      `CHK(cb, 1'b0)
      unit.step(1'b1, 1'b1, 4'h0, crpa_pkg::SRC_A, 1'b0, 8'h00, 0);
      bus(1'b0, 8'h00, 8'h00);
      `CHK(rd, 32'h30)
      unit.step(1'b1, 1'b0, 4'hc, crpa_pkg::SRC_A, 1'b0, 8'h00, 0);
      bus(1'b0, 8'h00, 8'h00);
      `CHK(rd, 32'h2f)
      bus(1'b0, 8'h04, 8'h00);
      `CHK(rd, 32'h3f)
      unit.step(1'b0, 1'b0, 4'h0, crpa_pkg::SRC_CPU, 1'b0, 8'h00, 0);
      cpu(1'b0, 8'h60, 8'h00);
      `CHK(cr, 8'h3c)
      // Stray unit write in standby must not reach the RAM
      unit.step(1'b0, 1'b0, 4'hf, crpa_pkg::SRC_R, 1'b1, 8'hff, 0);
      cpu(1'b0, 8'h60, 8'h00);
      `CHK(cr, 8'h3c)
      bus(1'b0, 8'h0c, 8'h00);
      `CHK(rd, 32'h11)
      bus(1'b0, 8'h08, 8'h00);
      `CHK(rd, 32'h60)
      cpu(1'b0, 8'h21, 8'h00);
      `CHK(cr, 8'ha5)
      `CHK(irqGrant, 1'b1)
      // Mid-run reset must bring the A, R and high pointers back to their reset value
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      bus(1'b0, 8'h00, 8'h00);
      `CHK(rd, 32'h0)
      bus(1'b0, 8'h08, 8'h00);
      `CHK(rd, 32'h0)
      bus(1'b0, 8'h0c, 8'h00);
      `CHK(rd, 32'h0)
      `CHK(hreadyout, 1'b1)
      `CHK(hresp, 1'b0)
      report_and_stop();
   end
endmodule : testbench
`undef CHK
`default_nettype wire
